/* rtl/sdt_cfg.svh */
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH
// Host port addresses and register indices
`define SDT_IDX_PORT      16'h03D6
`define SDT_DATA_PORT     16'h03D7
`define SDT_IDX_TIMING    8'h51
`define SDT_IDX_CONTROL   8'h52
`define SDT_IDX_EXT       8'h53
// Reset values and writable bit masks
`define SDT_RST_IDX       8'h00
`define SDT_RST_TIMING    8'h1C
`define SDT_RST_CONTROL   8'h10
`define SDT_RST_EXT       8'h01
`define SDT_MASK_TIMING   8'h3C
`define SDT_MASK_CONTROL  8'h17
`define SDT_MASK_EXT      8'h03
// Field positions
`define SDT_BIT_RCO       5
`define SDT_BIT_CL        4
`define SDT_BIT_RT        3
`define SDT_BIT_RPT       2
`define SDT_BIT_LFE       4
`define SDT_MODE_HI       2
`define SDT_MODE_LO       0
`define SDT_RATE_HI       1
`define SDT_RATE_LO       0
`define SDT_A10_BIT       10
// Refresh rate codes
`define SDT_RATE_OFF      2'h0
`define SDT_RATE_FAST     2'h2
// Timings in memory clocks
`define SDT_ACTIVATE_TO_COMMAND_DELAY_FORCED   4'h2
`define SDT_ACTIVATE_TO_COMMAND_DELAY_CL0      4'h2
`define SDT_ACTIVATE_TO_COMMAND_DELAY_CL1      4'h3
`define SDT_LAT_CL0       4'h2
`define SDT_LAT_CL1       4'h3
`define SDT_ACTIVATE_TO_PRECHARGE_TIME_RT0      4'h5
`define SDT_ACTIVATE_TO_PRECHARGE_TIME_RT1      4'h7
`define SDT_TRC_RT0       4'h8
`define SDT_TRC_RT1       4'hA
`define SDT_TRP_RPT0      4'h3
`define SDT_TRP_RPT1      4'h4
`define SDT_TMRD          4'h2
`define SDT_TWR           4'h2
// Refresh spacing: 15.6 us normal, 320 ns fast test, clock period in ps
`define SDT_CLK_PERIOD_PS 32'h0000_1388
`define SDT_REF_NS        32'h0000_3CF0
`define SDT_FAST_REF_NS   32'h0000_0140
`define SDT_REF_CYC       ((`SDT_REF_NS * 32'h0000_03E8) / `SDT_CLK_PERIOD_PS)
`define SDT_FAST_REF_CYC  ((`SDT_FAST_REF_NS * 32'h0000_03E8) / `SDT_CLK_PERIOD_PS)
`endif

/* rtl/sdt_pkg.sv */
package sdt_pkg;
  typedef enum logic [2:0] {
    SDT_MODE_NORMAL   = 3'h0,
    SDT_NOP_ISSUE     = 3'h1,
    SDT_ALL_BANK_PRE  = 3'h2,
    SDT_MODE_SET      = 3'h3,
    SDT_REFRESH_ISSUE = 3'h4
  } sdt_mode_e;
  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDT_CMD_NOP = 4'h7,
    SDT_CMD_ACT = 4'h3,
    SDT_CMD_RD  = 4'h5,
    SDT_CMD_WR  = 4'h4,
    SDT_CMD_PRE = 4'h2,
    SDT_CMD_REF = 4'h1,
    SDT_CMD_MRS = 4'h0
  } sdt_cmd_e;
  typedef enum logic [3:0] {
    SDT_ST_IDLE = 4'h0,
    SDT_ST_RCD  = 4'h1,
    SDT_ST_COL  = 4'h3,
    SDT_ST_HOLD = 4'h2,
    SDT_ST_WAIT = 4'h6
  } sdt_state_e;
  typedef struct packed {
    logic       row_col_override;
    logic       column_latency;
    logic       row_active_timing;
    logic       precharge_timing;
    logic       line_fetch_en;
    logic [2:0] special_command_mode;
    logic [1:0] refresh_rate_select;
  } sdt_cfg_s;
endpackage

/* rtl/sdt_link_if.sv */
`timescale 1ns/1ps
interface sdt_link_if import sdt_pkg::*; ();
  sdt_cfg_s cfg;
  logic     ref_req;
  logic     ref_ack;
  modport regs (output cfg);
  modport refr (input cfg, input ref_ack, output ref_req);
  modport seq  (input cfg, input ref_req, output ref_ack);
endinterface

/* rtl/sdt_regs.sv */
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_regs import sdt_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        host_cs,
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  sdt_link_if.regs         lnk
);
  logic [7:0] idx_r, idx_nxt, tim_r, tim_nxt, ctl_r, ctl_nxt;
  logic [7:0] ext_r, ext_nxt, rdata_r, rdata_nxt, data_val;

  always_comb begin
    idx_nxt   = idx_r;
    tim_nxt   = tim_r;
    ctl_nxt   = ctl_r;
    ext_nxt   = ext_r;
    rdata_nxt = rdata_r;
    case (idx_r)
      `SDT_IDX_TIMING:  data_val = tim_r;
      `SDT_IDX_CONTROL: data_val = ctl_r;
      `SDT_IDX_EXT:     data_val = ext_r;
      default:          data_val = 8'h00;
    endcase
    if (host_cs && host_addr == `SDT_IDX_PORT) begin
      if (host_we) begin
        idx_nxt = host_wdata;
      end else begin
        rdata_nxt = idx_r;
      end
    end else if (host_cs && host_addr == `SDT_DATA_PORT) begin
      if (host_we) begin
        case (idx_r)
          `SDT_IDX_TIMING:  tim_nxt = host_wdata & `SDT_MASK_TIMING;
          `SDT_IDX_CONTROL: ctl_nxt = host_wdata & `SDT_MASK_CONTROL;
          `SDT_IDX_EXT:     ext_nxt = host_wdata & `SDT_MASK_EXT;
          default:          ;
        endcase
      end else begin
        rdata_nxt = data_val;
      end
    end else if (host_cs && !host_we) begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idx_r   <= `SDT_RST_IDX;
      tim_r   <= `SDT_RST_TIMING;
      ctl_r   <= `SDT_RST_CONTROL;
      ext_r   <= `SDT_RST_EXT;
      rdata_r <= 8'h00;
    end else if (ce) begin
      idx_r   <= idx_nxt;
      tim_r   <= tim_nxt;
      ctl_r   <= ctl_nxt;
      ext_r   <= ext_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign host_rdata                   = rdata_r;
  assign lnk.cfg.row_col_override     = tim_r[`SDT_BIT_RCO];
  assign lnk.cfg.column_latency       = tim_r[`SDT_BIT_CL];
  assign lnk.cfg.row_active_timing    = tim_r[`SDT_BIT_RT];
  assign lnk.cfg.precharge_timing     = tim_r[`SDT_BIT_RPT];
  assign lnk.cfg.line_fetch_en        = ctl_r[`SDT_BIT_LFE];
  assign lnk.cfg.special_command_mode = ctl_r[`SDT_MODE_HI:`SDT_MODE_LO];
  assign lnk.cfg.refresh_rate_select  = ext_r[`SDT_RATE_HI:`SDT_RATE_LO];
endmodule

/* rtl/sdt_refresh.sv */
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_refresh import sdt_pkg::*; #(
  parameter int unsigned REF_CYC  = `SDT_REF_CYC,
  parameter int unsigned FAST_CYC = `SDT_FAST_REF_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ce,
  sdt_link_if.refr  lnk
);
  generate
    if (REF_CYC < 2 || REF_CYC > 65535 || FAST_CYC < 2 || FAST_CYC > 65535) begin : g_chk
      $error("sdt_refresh: refresh interval out of range");
    end
  endgenerate

  logic [15:0] cnt_r, cnt_nxt, lim;
  logic        pend_r, pend_nxt, fire;

  always_comb begin
    lim      = (lnk.cfg.refresh_rate_select == `SDT_RATE_FAST) ? 16'(FAST_CYC - 1)
                                                      : 16'(REF_CYC - 1);
    fire     = 1'b0;
    cnt_nxt  = cnt_r + 16'h0001;
    if (lnk.cfg.refresh_rate_select == `SDT_RATE_OFF) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r >= lim) begin
      cnt_nxt = 16'h0000;
      fire    = 1'b1;
    end
    pend_nxt = fire | (pend_r & ~lnk.ref_ack);
    if (lnk.cfg.refresh_rate_select == `SDT_RATE_OFF) begin
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= 16'h0000;
      pend_r <= 1'b0;
    end else if (ce) begin
      cnt_r  <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign lnk.ref_req = pend_r;
endmodule

/* rtl/sdt_ctrl.sv */
// Functional notes
// - Override bit forces activate-to-column delay 2
// - Latency bit picks latency/delay 2 or 3
// - Row bit picks row times 5/8 or 7/10
// - Precharge bit picks precharge 3 or 4
// - Line fetch bit picks quadword or cacheline
// - Mode 000 gives normal reads and writes
// - Mode 001 turns accesses into NOP
// - Mode 010 turns accesses into precharge-all
// - Mode 011 issues mode set from address
// - Mode set drives address lines 11:7 low
// - Mode 100 turns accesses into refresh
// - Rate 00 disables refresh, 01 normal rate
// - Rate 10 is fast refresh test mode
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_ctrl import sdt_pkg::*; #(
  parameter int unsigned REF_CYC   = `SDT_REF_CYC,
  parameter int unsigned FAST_CYC  = `SDT_FAST_REF_CYC,
  parameter int unsigned BURST_LEN = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        host_cs,
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  input  wire logic        acc_req,
  input  wire logic        acc_we,
  input  wire logic [19:0] acc_addr,
  output logic             acc_ack,
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic      [11:0] memory_address_lines,
  output logic             line_fetch_active
);
  generate
    if (BURST_LEN < 1 || BURST_LEN > 15) begin : g_chk
      $error("sdt_ctrl: BURST_LEN must be 1 to 15");
    end
  endgenerate

  sdt_link_if lnk ();

  sdt_regs u_regs (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .ce         (ce),
    .host_cs    (host_cs),
    .host_we    (host_we),
    .host_addr  (host_addr),
    .host_wdata (host_wdata),
    .host_rdata (host_rdata),
    .lnk        (lnk)
  );

  sdt_refresh #(
    .REF_CYC  (REF_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_refresh (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .lnk     (lnk)
  );

  sdt_state_e  state_r, state_nxt;
  sdt_cmd_e    cmd_r, cmd_nxt;
  sdt_cfg_s    cfg_r, cfg_nxt, cfg_use;
  logic [11:0] addr_r, addr_nxt;
  logic [7:0]  col_r, col_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [3:0]  ras_cnt_r, ras_cnt_nxt;
  logic [3:0]  beat_r, beat_nxt;
  logic        rd_r, rd_nxt;
  logic        pend_r, pend_nxt;
  logic        ack_r, ack_nxt;
  logic        ref_ack_r, ref_ack_nxt;
  logic [3:0]  t_rcd, t_lat, t_ras, t_rc, t_rp, beats;

  // Timing set in force: live registers while idle, frozen snapshot otherwise
  always_comb begin
    cfg_use = (state_r == SDT_ST_IDLE) ? lnk.cfg : cfg_r;
    if (cfg_use.row_col_override) begin
      t_rcd = `SDT_ACTIVATE_TO_COMMAND_DELAY_FORCED;
    end else begin
      t_rcd = cfg_use.column_latency ? `SDT_ACTIVATE_TO_COMMAND_DELAY_CL1 : `SDT_ACTIVATE_TO_COMMAND_DELAY_CL0;
    end
    t_lat = cfg_use.column_latency ? `SDT_LAT_CL1 : `SDT_LAT_CL0;
    t_ras = cfg_use.row_active_timing ? `SDT_ACTIVATE_TO_PRECHARGE_TIME_RT1 : `SDT_ACTIVATE_TO_PRECHARGE_TIME_RT0;
    t_rc  = cfg_use.row_active_timing ? `SDT_TRC_RT1 : `SDT_TRC_RT0;
    t_rp  = cfg_use.precharge_timing ? `SDT_TRP_RPT1 : `SDT_TRP_RPT0;
    beats = cfg_use.line_fetch_en ? 4'(BURST_LEN) : 4'h1;
  end

  always_comb begin
    state_nxt   = state_r;
    cmd_nxt     = SDT_CMD_NOP;
    cfg_nxt     = cfg_r;
    addr_nxt    = addr_r;
    col_nxt     = col_r;
    cnt_nxt     = cnt_r;
    beat_nxt    = beat_r;
    rd_nxt      = rd_r;
    pend_nxt    = pend_r;
    ack_nxt     = 1'b0;
    ref_ack_nxt = 1'b0;
    ras_cnt_nxt = (ras_cnt_r == 4'hF) ? ras_cnt_r : ras_cnt_r + 4'h1;
    case (state_r)
      SDT_ST_IDLE: begin
        cfg_nxt = lnk.cfg;
        if (lnk.ref_req) begin
          cmd_nxt     = SDT_CMD_REF;
          ref_ack_nxt = 1'b1;
          cnt_nxt     = t_rc - 4'h1;
          state_nxt   = SDT_ST_WAIT;
        end else if (acc_req && !ack_r) begin
          pend_nxt  = 1'b1;
          state_nxt = SDT_ST_WAIT;
          cnt_nxt   = 4'h0;
          case (lnk.cfg.special_command_mode)
            SDT_MODE_NORMAL: begin
              cmd_nxt     = SDT_CMD_ACT;
              addr_nxt    = acc_addr[19:8];
              col_nxt     = acc_addr[7:0];
              rd_nxt      = !acc_we;
              ras_cnt_nxt = 4'h0;
              cnt_nxt     = t_rcd - 4'h1;
              state_nxt   = SDT_ST_RCD;
            end
            SDT_NOP_ISSUE: begin
              cmd_nxt = SDT_CMD_NOP;
            end
            SDT_ALL_BANK_PRE: begin
              cmd_nxt                = SDT_CMD_PRE;
              addr_nxt               = 12'h000;
              addr_nxt[`SDT_A10_BIT] = 1'b1;
              cnt_nxt                = t_rp - 4'h1;
            end
            SDT_MODE_SET: begin
              cmd_nxt  = SDT_CMD_MRS;
              addr_nxt = {5'h00, acc_addr[6:0]};
              cnt_nxt  = `SDT_TMRD - 4'h1;
            end
            SDT_REFRESH_ISSUE: begin
              cmd_nxt = SDT_CMD_REF;
              cnt_nxt = t_rc - 4'h1;
            end
            default: begin
              cmd_nxt = SDT_CMD_NOP;
            end
          endcase
        end
      end
      SDT_ST_RCD: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          cmd_nxt  = rd_r ? SDT_CMD_RD : SDT_CMD_WR;
          addr_nxt = {4'h0, col_r};
          col_nxt  = col_r + 8'h01;
          beat_nxt = beats - 4'h1;
          if (beats == 4'h1) begin
            state_nxt = SDT_ST_HOLD;
            cnt_nxt   = rd_r ? t_lat - 4'h1 : `SDT_TWR - 4'h1;
          end else begin
            state_nxt = SDT_ST_COL;
          end
        end
      end
      SDT_ST_COL: begin
        cmd_nxt  = rd_r ? SDT_CMD_RD : SDT_CMD_WR;
        addr_nxt = {4'h0, col_r};
        col_nxt  = col_r + 8'h01;
        beat_nxt = beat_r - 4'h1;
        if (beat_r == 4'h1) begin
          state_nxt = SDT_ST_HOLD;
          cnt_nxt   = rd_r ? t_lat - 4'h1 : `SDT_TWR - 4'h1;
        end
      end
      SDT_ST_HOLD: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (ras_cnt_r >= t_ras - 4'h1) begin
          cmd_nxt   = SDT_CMD_PRE;
          addr_nxt  = 12'h000;
          cnt_nxt   = t_rp - 4'h1;
          state_nxt = SDT_ST_WAIT;
        end
      end
      SDT_ST_WAIT: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          ack_nxt   = pend_r;
          pend_nxt  = 1'b0;
          state_nxt = SDT_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SDT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r   <= SDT_ST_IDLE;
      cmd_r     <= SDT_CMD_NOP;
      cfg_r     <= {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 2'h1};
      addr_r    <= 12'h000;
      col_r     <= 8'h00;
      cnt_r     <= 4'h0;
      ras_cnt_r <= 4'h0;
      beat_r    <= 4'h0;
      rd_r      <= 1'b0;
      pend_r    <= 1'b0;
      ack_r     <= 1'b0;
      ref_ack_r <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      cmd_r     <= cmd_nxt;
      cfg_r     <= cfg_nxt;
      addr_r    <= addr_nxt;
      col_r     <= col_nxt;
      cnt_r     <= cnt_nxt;
      ras_cnt_r <= ras_cnt_nxt;
      beat_r    <= beat_nxt;
      rd_r      <= rd_nxt;
      pend_r    <= pend_nxt;
      ack_r     <= ack_nxt;
      ref_ack_r <= ref_ack_nxt;
    end
  end

  assign lnk.ref_ack          = ref_ack_r;
  assign acc_ack              = ack_r;
  assign mem_cs_n             = cmd_r[3];
  assign mem_ras_n            = cmd_r[2];
  assign mem_cas_n            = cmd_r[1];
  assign mem_we_n             = cmd_r[0];
  assign memory_address_lines = addr_r;
  assign line_fetch_active    = cfg_r.line_fetch_en;
endmodule

/* testbench/sdt_ctrl_assertions.sv */
`timescale 1ns/1ps
module sdt_ctrl_assertions import sdt_pkg::*; #(
  parameter int unsigned REF_CYC   = 20,
  parameter int unsigned FAST_CYC  = 4,
  parameter int unsigned BURST_LEN = 4
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        host_cs,
  input wire logic        host_we,
  input wire logic [15:0] host_addr,
  input wire logic [7:0]  host_wdata,
  input wire logic [7:0]  host_rdata,
  input wire logic        acc_req,
  input wire logic        acc_we,
  input wire logic [19:0] acc_addr,
  input wire logic        acc_ack,
  input wire logic        mem_cs_n,
  input wire logic        mem_ras_n,
  input wire logic        mem_cas_n,
  input wire logic        mem_we_n,
  input wire logic [11:0] memory_address_lines,
  input wire logic        line_fetch_active
);
  logic [3:0] cmd;
  logic       col;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign col = (cmd == SDT_CMD_RD) || (cmd == SDT_CMD_WR);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_burst_head;
    col && line_fetch_active && !$past(col);
  endsequence
  sequence s_burst_tail;
    col [*3];
  endsequence
  chk_mrs_high_zero: assert property (
    cmd == SDT_CMD_MRS |-> memory_address_lines[11:7] == 5'h00)
    else $error("mode set upper address not zero");
  chk_mrs_low_bits: assert property (
    cmd == SDT_CMD_MRS |-> memory_address_lines[6:0] == acc_addr[6:0])
    else $error("mode set low address wrong");
  chk_rcd_min: assert property (
    cmd == SDT_CMD_ACT |=> !col)
    else $error("column command too soon after activate");
  chk_ras_min: assert property (
    cmd == SDT_CMD_ACT |=> (cmd != SDT_CMD_PRE) [*4])
    else $error("precharge too soon after activate");
  chk_rp_min: assert property (
    cmd == SDT_CMD_PRE |=> (cmd != SDT_CMD_ACT) [*2])
    else $error("activate too soon after precharge");
  chk_rc_min: assert property (
    cmd == SDT_CMD_REF |=> (cmd != SDT_CMD_ACT) [*7])
    else $error("activate too soon after refresh");
  chk_burst_run: assert property (
    s_burst_head |=> s_burst_tail)
    else $error("cacheline burst broken");
  chk_qword_single: assert property (
    col && !line_fetch_active |=> !col)
    else $error("quadword fetch gave more than one column");
endmodule
bind sdt_ctrl sdt_ctrl_assertions #(
  .REF_CYC(REF_CYC),
  .FAST_CYC(FAST_CYC),
  .BURST_LEN(BURST_LEN)
) u_chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .ce(ce),
  .host_cs(host_cs),
  .host_we(host_we),
  .host_addr(host_addr),
  .host_wdata(host_wdata),
  .host_rdata(host_rdata),
  .acc_req(acc_req),
  .acc_we(acc_we),
  .acc_addr(acc_addr),
  .acc_ack(acc_ack),
  .mem_cs_n(mem_cs_n),
  .mem_ras_n(mem_ras_n),
  .mem_cas_n(mem_cas_n),
  .mem_we_n(mem_we_n),
  .memory_address_lines(memory_address_lines),
  .line_fetch_active(line_fetch_active)
);

/* testbench/sdt_mem_model.sv */
`timescale 1ns/1ps
module sdt_mem_model import sdt_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_ras_n,
  input  wire logic        mem_cas_n,
  input  wire logic        mem_we_n,
  input  wire logic [11:0] memory_address_lines,
  output logic      [3:0]  last_cmd,
  output logic      [11:0] last_addr,
  output logic      [7:0]  n_cmd,
  output logic      [7:0]  n_col,
  output logic      [7:0]  n_ref,
  output logic      [7:0]  act_to_col,
  output logic      [7:0]  act_to_pre
);
  logic [3:0] cmd;
  logic [7:0] since_act;
  logic       col_seen;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  // Memory side: logs commands and row spacing
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_cmd <= SDT_CMD_NOP;
      last_addr <= 12'h000;
      {n_cmd, n_col, n_ref, act_to_col, act_to_pre, since_act} <= '0;
      col_seen <= 1'b0;
    end else begin
      since_act <= since_act + 8'h01;
      if (cmd != SDT_CMD_NOP) begin
        n_cmd <= n_cmd + 8'h01;
        last_cmd <= cmd;
        last_addr <= memory_address_lines;
      end
      if (cmd == SDT_CMD_ACT) begin
        since_act <= 8'h01;
        col_seen <= 1'b0;
      end
      if (cmd == SDT_CMD_RD || cmd == SDT_CMD_WR) begin
        n_col <= n_col + 8'h01;
        col_seen <= 1'b1;
        if (!col_seen) act_to_col <= since_act;
      end
      if (cmd == SDT_CMD_PRE) act_to_pre <= since_act;
      if (cmd == SDT_CMD_REF) n_ref <= n_ref + 8'h01;
    end
  end
endmodule

/* testbench/sdram_timing_command_config_tb_top.sv */
`timescale 1ns/1ps
`include "sdt_cfg.svh"
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end
module sdram_timing_command_config_tb_top import sdt_pkg::*; ();
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        host_cs = 1'b0;
  logic        host_we = 1'b0;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0]  host_wdata = 8'h00;
  logic        acc_req = 1'b0;
  logic        acc_we = 1'b0;
  logic [19:0] acc_addr = 20'h0_0000;
  logic [7:0]  host_rdata;
  logic        acc_ack, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, line_fetch_active;
  logic [11:0] memory_address_lines, last_addr;
  logic [3:0]  last_cmd;
  logic [7:0]  n_cmd, n_col, n_ref, act_to_col, act_to_pre;
  int          n_errors = 0;
  int          checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  sdt_ctrl #(.REF_CYC(20), .FAST_CYC(4), .BURST_LEN(4)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(1'b1),
    .host_cs(host_cs), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr), .acc_ack(acc_ack),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .memory_address_lines(memory_address_lines),
    .line_fetch_active(line_fetch_active));
  sdt_mem_model u_mem (
    .clk_sys(clk_sys), .rstn(rstn), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .memory_address_lines(memory_address_lines), .last_cmd(last_cmd),
    .last_addr(last_addr), .n_cmd(n_cmd), .n_col(n_col), .n_ref(n_ref),
    .act_to_col(act_to_col), .act_to_pre(act_to_pre));
  task automatic host_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_cs <= 1'b1;
    host_we <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk_sys);
    host_cs <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    host_wr(`SDT_IDX_PORT, idx);
    host_wr(`SDT_DATA_PORT, d);
  endtask
  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
    host_wr(`SDT_IDX_PORT, idx);
    @(posedge clk_sys);
    host_cs <= 1'b1;
    host_we <= 1'b0;
    host_addr <= `SDT_DATA_PORT;
    @(posedge clk_sys);
    host_cs <= 1'b0;
    @(posedge clk_sys);
    d = host_rdata;
  endtask
  task automatic acc(input logic we, input logic [19:0] a);
    int n;
    @(posedge clk_sys);
    acc_req <= 1'b1;
    acc_we <= we;
    acc_addr <= a;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (acc_ack !== 1'b1 && n < 200);
    acc_req <= 1'b0;
    `CHK("ack", 1'b1, acc_ack)
  endtask
  task automatic test_regs();
    logic [7:0] d;
    reg_rd(8'h51, d);
    `CHK("timing", 8'h1C, d)
    reg_rd(8'h52, d);
    `CHK("control", 8'h10, d)
    reg_rd(8'h53, d);
    `CHK("ext", 8'h01, d)
    reg_rd(8'h50, d);
    `CHK("unmapped", 8'h00, d)
    reg_wr(8'h51, 8'hFF);
    reg_rd(8'h51, d);
    `CHK("mask", 8'h3C, d)
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_rd(8'h51, d);
    `CHK("rereset", 8'h1C, d)
    $display("test_regs done");
  endtask
  task automatic test_timing();
    logic [7:0] cfg [5] = '{8'h1C, 8'h00, 8'h3C, 8'h10, 8'h08};
    logic [7:0] rcd [5] = '{8'h03, 8'h02, 8'h02, 8'h03, 8'h02};
    logic [7:0] ras [5] = '{8'h07, 8'h05, 8'h07, 8'h05, 8'h07};
    logic [7:0] n0;
    reg_wr(8'h53, 8'h00);
    reg_wr(8'h52, 8'h00);
    for (int i = 0; i < 5; i++) begin
      n0 = n_col;
      reg_wr(8'h51, cfg[i]);
      acc(i[0], 20'h1_2345);
      `CHK("rcd", rcd[i], act_to_col)
      `CHK("ras", ras[i], act_to_pre)
      `CHK("qword", n0 + 8'h01, n_col)
      `CHK("fetch", 1'b0, line_fetch_active)
    end
    reg_wr(8'h51, 8'h1C);
    fork
      acc(1'b0, 20'h2_0010);
      reg_wr(8'h51, 8'h00);
    join
    `CHK("mid_rcd", 8'h03, act_to_col)
    `CHK("mid_ras", 8'h07, act_to_pre)
    reg_wr(8'h52, 8'h10);
    n0 = n_col;
    acc(1'b0, 20'h3_0040);
    `CHK("line", n0 + 8'h04, n_col)
    `CHK("line_on", 1'b1, line_fetch_active)
    reg_wr(8'h52, 8'h00);
    $display("test_timing done");
  endtask
  task automatic test_special();
    logic [3:0] ex [5] = '{SDT_CMD_NOP, SDT_CMD_NOP, SDT_CMD_PRE, SDT_CMD_MRS, SDT_CMD_REF};
    logic [7:0] n0, r0;
    for (int m = 1; m < 5; m++) begin
      reg_wr(8'h52, 8'(m));
      n0 = n_cmd;
      r0 = n_ref;
      acc(1'b0, 20'h0_0FB2);
      `CHK("count", n0 + 8'(m > 1), n_cmd)
      if (m > 1) `CHK("cmd", ex[m], last_cmd)
      if (m == 2) `CHK("all_bank", 1'b1, last_addr[10])
      if (m == 3) `CHK("mrs_addr", 12'h032, last_addr)
      if (m == 4) `CHK("cbr", r0 + 8'h01, n_ref)
    end
    reg_wr(8'h52, 8'h00);
    $display("test_special done");
  endtask
  task automatic test_refresh();
    logic [7:0] r0, d1, d2;
    r0 = n_ref;
    repeat (100) @(posedge clk_sys);
    `CHK("ref_off", r0, n_ref)
    reg_wr(8'h53, 8'h01);
    r0 = n_ref;
    repeat (100) @(posedge clk_sys);
    d1 = n_ref - r0;
    `CHK("ref_norm", 1'b1, d1 >= 8'h03 && d1 <= 8'h05)
    reg_wr(8'h53, 8'h02);
    r0 = n_ref;
    repeat (100) @(posedge clk_sys);
    d2 = n_ref - r0;
    `CHK("ref_fast", 1'b1, d2 >= 8'h07)
    reg_wr(8'h53, 8'h01);
    $display("test_refresh done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    test_regs();
    test_timing();
    test_special();
    test_refresh();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
endmodule
